// ### gdc_map.vh
`ifndef GDC_MAP_VH
`define GDC_MAP_VH
// clock rate and timing figures
`define GDC_CLK_HZ         10000000
`define GDC_DEGLITCH_NS    40
`define GDC_MUTE_US        100
`define GDC_RST_PULSE_NS   1000
// fsm states
`define GDC_ST_IDLE        3'h0
`define GDC_ST_RUN         3'h1
`define GDC_ST_MUTE        3'h2
`define GDC_ST_PULSE       3'h3
`define GDC_ST_RECOVER     3'h4
// reset/enable source select
`define GDC_RSTSRC_MANUAL  2'h0
`define GDC_RSTSRC_NONINV  2'h1
`define GDC_RSTSRC_INV     2'h2
`endif

// ### gdc_sync.v
`timescale 1ns/10ps
`include "gdc_map.vh"
// =====================================================
// two-flop synchroniser for pin inputs
module gdc_sync #(
    parameter W = 2
) (
    clk,
    rstn,
    pinIn,
    syncOut
);
    input  wire         clk;
    input  wire         rstn;
    input  wire [W-1:0] pinIn;
    output wire [W-1:0] syncOut;

    reg [W-1:0] stage1_reg;
    reg [W-1:0] stage2_reg;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1_reg <= {W{1'b0}};
            stage2_reg <= {W{1'b0}};
        end else begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;
endmodule

// ### gdc_host_ctrl.v
`timescale 1ns/10ps
`include "gdc_map.vh"
// =====================================================
// host-side controller for the isolated gate driver
module gdc_host_ctrl #(
    parameter MUTE_CYC = ((`GDC_MUTE_US * (`GDC_CLK_HZ / 1000)) / 1000),
    parameter PULSE_CYC = ((`GDC_RST_PULSE_NS * (`GDC_CLK_HZ / 1000000)) / 1000)
) (
    clk,
    rstn,
    enableReq,
    rstSrcSel,
    autoRetry,
    pwmHigh,
    pwmLow,
    faultAlarmNPin,
    powerGoodPin,
    pwmNonInvPin,
    pwmInvPin,
    rstEnPin,
    driverReady,
    faultSeen,
    faultCount,
    busy
);
    input  wire        clk;
    input  wire        rstn;
    input  wire        enableReq;
    input  wire [1:0]  rstSrcSel;
    input  wire        autoRetry;
    input  wire        pwmHigh;
    input  wire        pwmLow;
    input  wire        faultAlarmNPin;
    input  wire        powerGoodPin;
    output reg         pwmNonInvPin;
    output reg         pwmInvPin;
    output reg         rstEnPin;
    output reg         driverReady;
    output reg         faultSeen;
    output reg  [7:0]  faultCount;
    output reg         busy;

    // least time rounds up; pulse must clear the 40 ns deglitch
    localparam integer DEGL_CYC =
        (`GDC_DEGLITCH_NS * (`GDC_CLK_HZ / 1000000) + 999) / 1000 + 1;
    localparam integer PULSE_LEN = (PULSE_CYC > DEGL_CYC) ? PULSE_CYC : DEGL_CYC;
    localparam integer MUTE_LEN = (MUTE_CYC > 1) ? MUTE_CYC : 1;

    wire [1:0] pinSync;
    // fault line is inverted ahead of the sync so a reset sync reads "no fault"
    wire       faultActive = pinSync[0];
    wire       pgood       = pinSync[1];

    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [31:0] cnt_reg;
    reg  [31:0] cnt_next;
    reg         rstEn_next;
    reg         nonInv_next;
    reg         inv_next;
    reg         faultFlag_next;
    reg  [7:0]  faultCnt_next;

    gdc_sync #(.W(2)) uSync (
        .clk    (clk),
        .rstn   (rstn),
        .pinIn  ({powerGoodPin, ~faultAlarmNPin}),
        .syncOut(pinSync)
    );

    // =====================================================
    // control sequence
    always @* begin
        state_next     = state_reg;
        cnt_next       = cnt_reg;
        faultFlag_next = faultSeen;
        faultCnt_next  = faultCount;
        // never both high; the driver would hold the gate low anyway
        nonInv_next    = pwmHigh & ~pwmLow;
        inv_next       = pwmLow;
        rstEn_next     = 1'b0;
        case (state_reg)
            `GDC_ST_IDLE: begin
                if (enableReq)
                    state_next = `GDC_ST_RUN;
            end
            `GDC_ST_RUN: begin
                case (rstSrcSel)
                    `GDC_RSTSRC_NONINV: rstEn_next = nonInv_next;
                    `GDC_RSTSRC_INV:    rstEn_next = ~inv_next;
                    default:            rstEn_next = 1'b1;
                endcase
                if (!enableReq) begin
                    state_next = `GDC_ST_IDLE;
                end else if (faultActive && rstSrcSel == `GDC_RSTSRC_MANUAL) begin
                    state_next     = `GDC_ST_MUTE;
                    cnt_next       = 32'h0;
                    faultFlag_next = 1'b1;
                    faultCnt_next  = (faultCount == 8'hff) ? faultCount : faultCount + 8'h01;
                end
            end
            `GDC_ST_MUTE: begin
                rstEn_next = 1'b1;
                if (!enableReq) begin
                    state_next = `GDC_ST_IDLE;
                end else if (cnt_reg >= MUTE_LEN - 1) begin
                    if (autoRetry) begin
                        state_next = `GDC_ST_PULSE;
                        cnt_next   = 32'h0;
                    end
                end else begin
                    cnt_next = cnt_reg + 32'h1;
                end
            end
            `GDC_ST_PULSE: begin
                rstEn_next = 1'b0;
                if (cnt_reg >= PULSE_LEN - 1) begin
                    state_next = `GDC_ST_RECOVER;
                    cnt_next   = 32'h0;
                end else begin
                    cnt_next = cnt_reg + 32'h1;
                end
            end
            `GDC_ST_RECOVER: begin
                // wait for released fault line to reach us through the sync
                rstEn_next = 1'b1;
                if (cnt_reg >= 32'h3) begin
                    state_next = faultActive ? `GDC_ST_MUTE : `GDC_ST_RUN;
                    cnt_next   = 32'h0;
                end else begin
                    cnt_next = cnt_reg + 32'h1;
                end
            end
            default: begin
                state_next = `GDC_ST_IDLE;
            end
        endcase
        if (state_next != `GDC_ST_RUN) begin
            nonInv_next = 1'b0;
            inv_next    = 1'b0;
        end
        if (!enableReq)
            faultFlag_next = 1'b0;
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg    <= `GDC_ST_IDLE;
            cnt_reg      <= 32'h0;
            rstEnPin     <= 1'b0;
            pwmNonInvPin <= 1'b0;
            pwmInvPin    <= 1'b0;
            driverReady  <= 1'b0;
            faultSeen    <= 1'b0;
            faultCount   <= 8'h00;
            busy         <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            rstEnPin     <= rstEn_next;
            pwmNonInvPin <= nonInv_next;
            pwmInvPin    <= inv_next;
            driverReady  <= pgood & ~faultActive;
            faultSeen    <= faultFlag_next | (faultActive & (state_reg == `GDC_ST_RUN));
            faultCount   <= faultCnt_next;
            busy         <= (state_next == `GDC_ST_MUTE) || (state_next == `GDC_ST_PULSE)
                            || (state_next == `GDC_ST_RECOVER);
        end
    end
endmodule

// ### gdc_host_ctrl_checker.sv
`timescale 1ns/10ps
// ==========
// checker
module gdc_host_checker #(parameter MUTE_CYC = 8) (
    input wire       clk,
    input wire       rstn,
    input wire       enableReq,
    input wire [1:0] rstSrcSel,
    input wire       pwmHigh,
    input wire       pwmLow,
    input wire       faultAlarmNPin,
    input wire       powerGoodPin,
    input wire       pwmNonInvPin,
    input wire       pwmInvPin,
    input wire       rstEnPin,
    input wire       driverReady,
    input wire       faultSeen,
    input wire       busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_NO_OVERLAP: assert property (!(pwmNonInvPin && pwmInvPin))
        else $error("both pwm pins high");
    AST_IDLE_QUIET: assert property (!enableReq[*3] |-> !pwmNonInvPin && !pwmInvPin)
        else $error("pwm pins active while disabled");
    AST_SEEN_CLEAR: assert property (!enableReq |=> !faultSeen)
        else $error("fault flag not cleared");
    AST_FAULT_SEEN: assert property ($fell(faultAlarmNPin) && enableReq && rstSrcSel == 2'h0
        |-> ##[1:4] faultSeen)
        else $error("fault not flagged");
    AST_MUTE_WAIT: assert property (busy && $fell(rstEnPin) |-> $past(busy, MUTE_CYC))
        else $error("reset pulse before mute interval");
    AST_PULSE_LEN: assert property (busy && $fell(rstEnPin) |-> !rstEnPin[*2] ##[1:2] rstEnPin)
        else $error("reset pulse length wrong");
    AST_NONINV_RST: assert property ((enableReq && rstSrcSel == 2'h1 && $stable(pwmHigh)
        && $stable(pwmLow))[*3] |-> rstEnPin == pwmNonInvPin)
        else $error("reset/enable not following pwm");
    AST_INV_RST: assert property ((enableReq && rstSrcSel == 2'h2 && $stable(pwmHigh)
        && $stable(pwmLow))[*3] |-> rstEnPin == !pwmInvPin)
        else $error("reset/enable not inverse of pwm");
    AST_READY: assert property (!powerGoodPin[*4] |-> !driverReady)
        else $error("ready without power good");
endmodule
bind gdc_host_ctrl gdc_host_checker #(.MUTE_CYC(MUTE_CYC)) i_gdc_host_checker (.*);

// ### gdc_drv_model.sv
`timescale 1ns/10ps
// ==========
// behavioural driver, no clock of its own
module gdc_drv_model (
    input  wire inPos,
    input  wire inNeg,
    input  wire rstEn,
    input  wire ocEvent,
    input  wire uvlo,
    output wire faultAlarmN,
    output wire powerGood,
    output wire gateOut,
    output wire clampDrive
);
    reg  latched = 1'b0;
    wire inPosF;
    wire inNegF;
    wire rstEff;
    // inertial delays swallow pulses under the deglitch width
    assign #40 inPosF = inPos;
    assign #40 inNegF = inNeg;
    // undriven pin reads low through the pulldown
    assign #40 rstEff = (rstEn === 1'b1);
    always @(posedge ocEvent or negedge rstEff) begin
        latched <= rstEff;
    end
    // driven both ways: low while the fault is latched, high otherwise
    assign faultAlarmN = latched ? 1'b0 : 1'b1;
    assign powerGood   = uvlo ? 1'b0 : 1'b1;
    assign gateOut     = rstEff && !latched && inPosF && !inNegF;
    // gate low counts as below clamp threshold; clamp holds it there
    assign clampDrive  = !gateOut;
endmodule

// ### gdc_host_ctrl_tb_top.sv
`timescale 1ns/10ps
// ==========
// testbench
module gdc_host_ctrl_tb_top;
    reg clk = 1'b0, rstn = 1'b0, enableReq = 1'b0, autoRetry = 1'b0, pwmHigh = 1'b0;
    reg pwmLow = 1'b0, ocEvent = 1'b0, uvlo = 1'b0;
    reg [1:0] rstSrcSel = 2'h0;
    wire nonInv, inv, rstEn, fltN, pGood, gate, ready, seen, busy, clamp;
    wire [7:0] fcnt;
    integer fails = 0, n_compared = 0, cyc = 0, k;
    gdc_host_ctrl #(.MUTE_CYC(8), .PULSE_CYC(2)) i_gdc_host_ctrl (.clk(clk), .rstn(rstn),
        .enableReq(enableReq), .rstSrcSel(rstSrcSel), .autoRetry(autoRetry),
        .pwmHigh(pwmHigh), .pwmLow(pwmLow), .faultAlarmNPin(fltN), .powerGoodPin(pGood),
        .pwmNonInvPin(nonInv), .pwmInvPin(inv), .rstEnPin(rstEn), .driverReady(ready),
        .faultSeen(seen), .faultCount(fcnt), .busy(busy));
    gdc_drv_model i_gdc_drv_model (.inPos(nonInv), .inNeg(inv), .rstEn(rstEn),
        .ocEvent(ocEvent), .uvlo(uvlo), .faultAlarmN(fltN), .powerGood(pGood), .gateOut(gate),
        .clampDrive(clamp));
    initial forever #50 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            fails = fails + 1;
            tally_and_finish;
        end
    end
    task check(input [15:0] got, input [15:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask
    task w(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task fault;
        ocEvent = 1'b1;
        w(1);
        ocEvent = 1'b0;
        w(5);
    endtask
    task t_run;
        enableReq = 1'b1; pwmHigh = 1'b1; w(5);
        check(rstEn, 1'b1);
        check(gate, 1'b1);
        pwmLow = 1'b1; w(4);
        check(gate, 1'b0);
        check(clamp, 1'b1);
        pwmLow = 1'b0; w(4);
        $display("test run done");
    endtask
    task t_manual;
        autoRetry = 1'b1; fault;
        check({seen, busy, gate, fltN}, 4'hc);
        for (k = 0; k < 60 && busy !== 1'b0; k = k + 1) w(1);
        w(2);
        check({fltN, gate, fcnt}, 10'h301);
        $display("test manual done");
    endtask
    task t_auto(input [1:0] mode);
        rstSrcSel = mode; pwmHigh = 1'b1; pwmLow = 1'b0; w(5);
        fault;
        check({fltN, gate}, 2'h0);
        pwmHigh = (mode == 2'h2); pwmLow = (mode == 2'h2); w(5);
        pwmHigh = 1'b1; pwmLow = 1'b0; w(5);
        check({fltN, gate}, 2'h3);
        $display("test auto done");
    endtask
    task t_off;
        uvlo = 1'b1; enableReq = 1'b0; w(5);
        check({ready, seen, nonInv, inv, gate}, 5'h0);
        uvlo = 1'b0; w(5);
        check(ready, 1'b1);
        $display("test off done");
    endtask
    task tally_and_finish;
        $display("compared=%0d mismatches=%0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        w(8);
        rstn = 1'b1; w(2);
        t_run; t_manual; t_auto(2'h1); t_auto(2'h2);
        rstSrcSel = 2'h0; t_off;
        tally_and_finish;
    end
endmodule
